// ### adc_port_pkg.sv
// constants, command layout and state types shared by both ends of the
// serial command port.
// assumes both ends run from one 10 MHz core clock of their own.
package adc_port_pkg;

   // ***************************************************************
   // timing
   // ***************************************************************
   localparam int CORE_CLK_NS = 100;
   // host serial clock half period; long enough for two synchronisers
   localparam int SCLK_HALF_NS = 800;
   localparam logic [3:0] SCLK_HALF_CYC = 4'(SCLK_HALF_NS / CORE_CLK_NS);

   // ***************************************************************
   // command byte layout, first bit on the wire is bit 7
   // ***************************************************************
   localparam int CMD_BITS = 8;
   localparam int WGATE_POS = 7;
   localparam int FIXED_POS = 6;
   localparam int RSEL_HI_POS = 5;
   localparam int RSEL_LO_POS = 4;
   localparam int RNW_POS = 3;
   localparam int CONTINUOUS_READ_BIT_POS = 2;
   localparam int CH_HI_POS = 1;
   localparam int CH_LO_POS = 0;
   localparam logic [7:0] CMD_RST = 8'h00;

   // ***************************************************************
   // register selection and reset values
   // ***************************************************************
   localparam logic [1:0] SEL_STATUS = 2'h0;
   localparam logic [1:0] SEL_MODE = 2'h1;
   localparam logic [1:0] SEL_FILTER = 2'h2;
   localparam logic [1:0] SEL_DATA = 2'h3;
   localparam int STATUS_READY_POS = 7;
   localparam logic [7:0] MODE_RST = 8'h00;
   localparam logic [7:0] FILTER_RST = 8'h00;
   localparam logic [23:0] DATA_RST = 24'h000000;
   localparam logic [4:0] LEN_NONE = 5'h00;
   localparam logic [4:0] LEN_REG = 5'h08;
   localparam logic [4:0] LEN_DATA = 5'h18;
   localparam logic [5:0] RECOVER_ONES = 6'h20;

   // ***************************************************************
   // state types
   // ***************************************************************
   typedef enum logic [1:0] {
      DEV_IDLE = 2'h0,
      DEV_CMD = 2'h1,
      DEV_WRITE = 2'h3,
      DEV_READ = 2'h2
   } dev_state_t;

   typedef enum logic [1:0] {
      HOST_IDLE = 2'h0,
      HOST_LOW = 2'h1,
      HOST_HIGH = 2'h3,
      HOST_END = 2'h2
   } host_state_t;

   // data bits that follow a command byte
   function automatic logic [4:0] access_len(input logic [7:0] cmd);
      logic [1:0] sel;
      sel = {cmd[RSEL_HI_POS], cmd[RSEL_LO_POS]};
      if (cmd[RNW_POS]) begin
         access_len = (sel == SEL_DATA) ? LEN_DATA : LEN_REG;
      end else if (sel == SEL_MODE || sel == SEL_FILTER) begin
         access_len = LEN_REG;
      end else begin
         access_len = LEN_NONE;
      end
   endfunction

endpackage

// ### adc_port_if.sv
// serial link between the converter port and its host.
// assumes the serial output line has a pull-up while nobody drives it.
`timescale 1ns/1ps
`default_nettype none
interface adc_port_if;
   logic sclk;
   logic cs_n;
   logic din;
   logic dout;
   logic dout_oe_n;
   logic dout_line;

   // released line floats high
   assign dout_line = dout_oe_n ? 1'b1 : dout;

   modport dev (
      input sclk,
      input cs_n,
      input din,
      output dout,
      output dout_oe_n
   );

   modport host (
      output sclk,
      output cs_n,
      output din,
      input dout_line
   );
endinterface
`default_nettype wire

// ### adc_port_dev.sv
// converter end of the serial command port: command byte decode,
// register shifting, ready signalling and 32-ones recovery.
// assumes a conversion engine on core_clk giving conv_done and
// update_soon pulses; link pins are asynchronous to core_clk.
`timescale 1ns/1ps
`default_nettype none

// Operation
// R1 - serial output goes low on finished conversion
// R2 - unread result: line high before next update
// R3 - host may use falling edge as interrupt
// R4 - output bits change on falling serial clock
// R5 - deselected: output released, flag keeps updating
// R6 - conversion ready flag held in status register
// R7 - any register loadable into output shifter
// R8 - written bits go to selected control register
// R9 - command register: eight bits, write only
// R10 - host opens every access with command byte
// R11 - after access, back to waiting for command
// R12 - after reset, interface waits for command
// R13 - 32 ones on input resets whole part
// R14 - command byte sent most significant first
// R15 - command byte field layout fixed
// R16 - command bits reset to zero
// R17 - leading one holds position, loads nothing
// R18 - read_not_write: 0 write, 1 read
// R19 - register_select picks the addressed register
// R20 - host may tie chip select low
// R21 - input sampled on rising serial clock
module adc_port_dev (
   // clock and reset
   input wire logic core_clk,
   input wire logic srst,
   // serial link
   adc_port_if.dev link,
   // conversion engine
   input wire logic conv_done,
   input wire logic [23:0] conv_data,
   input wire logic update_soon,
   // configuration and status
   output logic [7:0] mode_q,
   output logic [7:0] filter_q,
   output logic [1:0] channel_q,
   output logic continuous_read_bit_q,
   output logic ready_q
);

   // ***************************************************************
   // state
   // ***************************************************************
   typedef struct packed {
      logic sclk_s1;
      logic sclk_s2;
      logic sclk_d;
      logic cs_s1;
      logic cs_s2;
      logic din_s1;
      logic din_s2;
      adc_port_pkg::dev_state_t state;
      logic [7:0] cmd;
      logic [7:0] in_sh;
      logic [23:0] out_sh;
      logic [4:0] cnt;
      logic [4:0] len;
      logic [5:0] ones;
      logic [7:0] mode;
      logic [7:0] filter;
      logic [23:0] data;
      logic ready;
      logic dout;
      logic oe_n;
   } dev_st_t;

   dev_st_t st_ff;
   dev_st_t nxt_st;

   // functional state to reset values, synchronisers left as given
   function automatic dev_st_t fresh(input dev_st_t s);
      dev_st_t r;
      r = s;
      r.state = adc_port_pkg::DEV_IDLE; // R12
      r.cmd = adc_port_pkg::CMD_RST; // R16
      r.in_sh = 8'h00;
      r.out_sh = 24'h000000;
      r.cnt = 5'h00;
      r.len = 5'h00;
      r.ones = 6'h00;
      r.mode = adc_port_pkg::MODE_RST;
      r.filter = adc_port_pkg::FILTER_RST;
      r.data = adc_port_pkg::DATA_RST;
      r.ready = 1'b0;
      r.dout = 1'b1;
      r.oe_n = 1'b1;
      return r;
   endfunction

   // ***************************************************************
   // next state
   // ***************************************************************
   always_comb begin
      logic rise;
      logic fall;
      logic sel;
      logic bit_in;
      logic [7:0] new_cmd;
      logic [1:0] rsel;
      logic [7:0] status;
      rise = 1'b0;
      fall = 1'b0;
      sel = 1'b0;
      bit_in = 1'b0;
      new_cmd = 8'h00;
      rsel = 2'h0;
      status = 8'h00;
      nxt_st = st_ff;

      // first stage feeds only the second
      nxt_st.sclk_s1 = link.sclk;
      nxt_st.sclk_s2 = st_ff.sclk_s1;
      nxt_st.sclk_d = st_ff.sclk_s2;
      nxt_st.cs_s1 = link.cs_n;
      nxt_st.cs_s2 = st_ff.cs_s1;
      nxt_st.din_s1 = link.din;
      nxt_st.din_s2 = st_ff.din_s1;
      rise = st_ff.sclk_s2 & ~st_ff.sclk_d;
      fall = ~st_ff.sclk_s2 & st_ff.sclk_d;
      sel = ~st_ff.cs_s2;
      bit_in = st_ff.din_s2;

      // conversion events run whatever the chip select does
      if (update_soon) begin
         nxt_st.ready = 1'b0; // R2
      end

      // ***************************************************************
      // input side, one bit per rising serial clock
      // ***************************************************************
      if (sel && rise) begin // R21
         nxt_st.in_sh = {st_ff.in_sh[6:0], bit_in}; // R14
         nxt_st.cnt = st_ff.cnt + 5'h01;
         case (st_ff.state)
            adc_port_pkg::DEV_IDLE: begin
               nxt_st.cnt = 5'h00;
               // a one here is not a start: stay on this bit
               if (!bit_in) begin
                  nxt_st.state = adc_port_pkg::DEV_CMD; // R17
               end
            end
            adc_port_pkg::DEV_CMD: begin
               if (st_ff.cnt == 5'h06) begin
                  new_cmd = {1'b0, st_ff.in_sh[5:0], bit_in}; // R9 R15
                  rsel = {new_cmd[adc_port_pkg::RSEL_HI_POS],
                          new_cmd[adc_port_pkg::RSEL_LO_POS]}; // R19
                  status = 8'h00;
                  status[adc_port_pkg::STATUS_READY_POS] = st_ff.ready; // R6
                  status[1:0] = st_ff.cmd[1:0];
                  nxt_st.cmd = new_cmd;
                  nxt_st.cnt = 5'h00;
                  nxt_st.len = adc_port_pkg::access_len(new_cmd);
                  case (rsel) // R7
                     adc_port_pkg::SEL_STATUS: begin
                        nxt_st.out_sh = {status, 16'h0000};
                     end
                     adc_port_pkg::SEL_MODE: begin
                        nxt_st.out_sh = {st_ff.mode, 16'h0000};
                     end
                     adc_port_pkg::SEL_FILTER: begin
                        nxt_st.out_sh = {st_ff.filter, 16'h0000};
                     end
                     default: begin
                        nxt_st.out_sh = st_ff.data;
                     end
                  endcase
                  if (adc_port_pkg::access_len(new_cmd) ==
                      adc_port_pkg::LEN_NONE) begin
                     nxt_st.state = adc_port_pkg::DEV_IDLE; // R11
                  end else if (new_cmd[adc_port_pkg::RNW_POS]) begin
                     nxt_st.state = adc_port_pkg::DEV_READ; // R18
                  end else begin
                     nxt_st.state = adc_port_pkg::DEV_WRITE; // R18
                  end
               end
            end
            adc_port_pkg::DEV_WRITE: begin
               if (st_ff.cnt == st_ff.len - 5'h01) begin
                  if (st_ff.cmd[adc_port_pkg::RSEL_LO_POS]) begin
                     nxt_st.mode = {st_ff.in_sh[6:0], bit_in}; // R8
                  end else begin
                     nxt_st.filter = {st_ff.in_sh[6:0], bit_in}; // R8
                  end
                  nxt_st.state = adc_port_pkg::DEV_IDLE; // R11
               end
            end
            adc_port_pkg::DEV_READ: begin
               if (st_ff.cnt == st_ff.len - 5'h01) begin
                  // a result read out is no longer fresh
                  if ({st_ff.cmd[adc_port_pkg::RSEL_HI_POS],
                       st_ff.cmd[adc_port_pkg::RSEL_LO_POS]} ==
                      adc_port_pkg::SEL_DATA) begin
                     nxt_st.ready = 1'b0; // R2
                  end
                  nxt_st.state = adc_port_pkg::DEV_IDLE; // R11
               end
            end
            default: begin
               nxt_st.state = adc_port_pkg::DEV_IDLE;
            end
         endcase

         // recovery counts ones in any state, even mid-read
         if (bit_in) begin
            if (st_ff.ones == adc_port_pkg::RECOVER_ONES - 6'h01) begin
               nxt_st = fresh(nxt_st); // R13
            end else begin
               nxt_st.ones = st_ff.ones + 6'h01; // R13
            end
         end else begin
            nxt_st.ones = 6'h00;
         end
      end

      // a new result wins over any clear in the same cycle
      if (conv_done) begin
         nxt_st.data = conv_data;
         nxt_st.ready = 1'b1; // R1 R6
      end

      // ***************************************************************
      // output side
      // ***************************************************************
      if (nxt_st.state == adc_port_pkg::DEV_READ &&
          st_ff.state == adc_port_pkg::DEV_READ) begin
         if (sel && fall) begin
            nxt_st.dout = st_ff.out_sh[23]; // R4
            nxt_st.out_sh = {st_ff.out_sh[22:0], 1'b0}; // R4
         end
      end else if (nxt_st.state != adc_port_pkg::DEV_READ) begin
         // between accesses the line shows the ready flag, low = fresh
         nxt_st.dout = ~nxt_st.ready; // R1 R2
      end
      nxt_st.oe_n = st_ff.cs_s2; // R5

      if (srst) begin
         nxt_st = fresh(dev_st_t'('1)); // R12 R16
      end
   end

   // ***************************************************************
   // registers
   // ***************************************************************
   always_ff @(posedge core_clk) begin
      st_ff <= nxt_st;
   end

   assign link.dout = st_ff.dout;
   assign link.dout_oe_n = st_ff.oe_n;
   assign mode_q = st_ff.mode;
   assign filter_q = st_ff.filter;
   assign channel_q = {st_ff.cmd[adc_port_pkg::CH_HI_POS],
                       st_ff.cmd[adc_port_pkg::CH_LO_POS]};
   assign continuous_read_bit_q = st_ff.cmd[adc_port_pkg::CONTINUOUS_READ_BIT_POS];
   assign ready_q = st_ff.ready;

endmodule // adc_port_dev
`default_nettype wire

// ### adc_port_host.sv
// host end of the serial command port: makes the serial clock,
// sends a command byte and its data, reads back, and recovers.
// assumes user requests on core_clk; serial output is asynchronous.
`timescale 1ns/1ps
`default_nettype none
module adc_port_host (
   // clock and reset
   input wire logic core_clk,
   input wire logic srst,
   // serial link
   adc_port_if.host link,
   // user requests
   input wire logic start,
   input wire logic [7:0] cmd,
   input wire logic [23:0] wdata,
   input wire logic recover,
   input wire logic three_wire,
   // user answers
   output logic busy,
   output logic done,
   output logic [23:0] rdata,
   output logic data_ready
);

   // ***************************************************************
   // state
   // ***************************************************************
   typedef struct packed {
      adc_port_pkg::host_state_t state;
      logic [3:0] div;
      logic sclk;
      logic cs_n;
      logic din;
      logic [31:0] tx;
      logic [5:0] bits;
      logic [5:0] total;
      logic [23:0] rx;
      logic dout_s1;
      logic dout_s2;
      logic dout_d;
      logic busy;
      logic done;
      logic [23:0] rdata;
      logic irq;
   } host_st_t;

   host_st_t st_ff;
   host_st_t nxt_st;

   always_comb begin
      logic [4:0] len;
      logic half_done;
      len = adc_port_pkg::access_len(cmd);
      half_done = (st_ff.div == adc_port_pkg::SCLK_HALF_CYC - 4'h1);
      nxt_st = st_ff;
      nxt_st.dout_s1 = link.dout_line;
      nxt_st.dout_s2 = st_ff.dout_s1;
      nxt_st.dout_d = st_ff.dout_s2;
      nxt_st.done = 1'b0;
      nxt_st.irq = 1'b0;
      nxt_st.div = half_done ? 4'h0 : st_ff.div + 4'h1;

      case (st_ff.state)
         adc_port_pkg::HOST_IDLE: begin
            nxt_st.div = 4'h0;
            nxt_st.cs_n = ~three_wire; // R20
            // only visible while selected, hence three-wire use
            if (~st_ff.cs_n && st_ff.dout_d && ~st_ff.dout_s2) begin
               nxt_st.irq = 1'b1; // R3
            end
            if (recover) begin
               nxt_st.tx = 32'hffffffff; // R13
               nxt_st.total = 6'(adc_port_pkg::RECOVER_ONES);
            end else begin
               // every access opens with the command byte
               nxt_st.total = 6'(adc_port_pkg::CMD_BITS) + {1'b0, len}; // R10
               case (len)
                  adc_port_pkg::LEN_DATA: nxt_st.tx = {cmd, wdata}; // R15
                  adc_port_pkg::LEN_REG: nxt_st.tx = {cmd, wdata[7:0], 16'h0};
                  default: nxt_st.tx = {cmd, 24'h000000};
               endcase
            end
            if (start || recover) begin
               nxt_st.state = adc_port_pkg::HOST_LOW;
               nxt_st.busy = 1'b1;
               nxt_st.cs_n = 1'b0;
               nxt_st.sclk = 1'b0;
               nxt_st.din = nxt_st.tx[31]; // R14
               nxt_st.bits = 6'h00;
               nxt_st.rx = 24'h000000;
            end
         end
         adc_port_pkg::HOST_LOW: begin
            if (half_done) begin
               nxt_st.sclk = 1'b1;
               nxt_st.bits = st_ff.bits + 6'h01;
               if (st_ff.bits >= 6'(adc_port_pkg::CMD_BITS)) begin
                  nxt_st.rx = {st_ff.rx[22:0], st_ff.dout_s2};
               end
               nxt_st.state = adc_port_pkg::HOST_HIGH;
            end
         end
         adc_port_pkg::HOST_HIGH: begin
            if (half_done) begin
               if (st_ff.bits == st_ff.total) begin
                  nxt_st.state = adc_port_pkg::HOST_END;
               end else begin
                  nxt_st.sclk = 1'b0;
                  nxt_st.tx = {st_ff.tx[30:0], 1'b0};
                  nxt_st.din = st_ff.tx[30]; // R14
                  nxt_st.state = adc_port_pkg::HOST_LOW;
               end
            end
         end
         adc_port_pkg::HOST_END: begin
            nxt_st.cs_n = ~three_wire; // R20
            nxt_st.din = 1'b1;
            nxt_st.busy = 1'b0;
            nxt_st.done = 1'b1;
            nxt_st.rdata = st_ff.rx;
            nxt_st.state = adc_port_pkg::HOST_IDLE;
         end
         default: begin
            nxt_st.state = adc_port_pkg::HOST_IDLE;
         end
      endcase

      if (srst) begin
         nxt_st = '0;
         nxt_st.state = adc_port_pkg::HOST_IDLE;
         nxt_st.sclk = 1'b1;
         nxt_st.cs_n = 1'b1;
         nxt_st.din = 1'b1;
         nxt_st.dout_s1 = 1'b1;
         nxt_st.dout_s2 = 1'b1;
         nxt_st.dout_d = 1'b1;
      end
   end

   always_ff @(posedge core_clk) begin
      st_ff <= nxt_st;
   end

   assign link.sclk = st_ff.sclk;
   assign link.cs_n = st_ff.cs_n;
   assign link.din = st_ff.din;
   assign busy = st_ff.busy;
   assign done = st_ff.done;
   assign rdata = st_ff.rdata;
   assign data_ready = st_ff.irq;

endmodule // adc_port_host
`default_nettype wire

// ### adc_port_properties.sv
// assertions on the serial link between converter and host ends.
// assumes both ends share core_clk and srst.
`timescale 1ns/1ps
`default_nettype none
module adc_port_properties (
   // clock and reset
   input wire logic core_clk,
   input wire logic srst,
   // serial link
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic din,
   input wire logic dout,
   input wire logic dout_oe_n,
   input wire logic dout_line
);
   // ***************************************************************
   // helper counters
   // ***************************************************************
   logic sclk_ff;
   logic cs_ff;
   logic first_ff;
   logic [5:0] ones_ff;
   logic [5:0] bits_ff;
   logic [4:0] fall_ff;
   logic rise;
   assign rise = sclk && !sclk_ff && !cs_n;
   always_ff @(posedge core_clk) begin
      if (srst) begin
         sclk_ff <= 1'b1;
         cs_ff <= 1'b1;
         first_ff <= 1'b1;
         ones_ff <= 6'h00;
         bits_ff <= 6'h00;
         fall_ff <= 5'h1f;
      end else begin
         sclk_ff <= sclk;
         cs_ff <= cs_n;
         if (rise && din && ones_ff != 6'h20) begin
            ones_ff <= ones_ff + 6'h01;
         end else if (rise && !din) begin
            ones_ff <= 6'h00;
         end
         if (!cs_n && cs_ff) begin
            bits_ff <= 6'h00;
         end else if (rise && bits_ff != 6'h3f) begin
            bits_ff <= bits_ff + 6'h01;
         end
         if (rise && bits_ff == 6'h00) begin
            first_ff <= din;
         end
         // saturating so idle time never reopens the window
         if (!sclk && sclk_ff) begin
            fall_ff <= 5'h00;
         end else if (fall_ff != 5'h1f) begin
            fall_ff <= fall_ff + 5'h01;
         end
      end
   end

   // ***************************************************************
   // properties
   // ***************************************************************
   default clocking cb @(posedge core_clk); endclocking

   a_reset_defaults: assert property (
      srst |=> dout_oe_n && dout && sclk && cs_n && din)
      else $error("link not at rest after reset");
   a_idle_released: assert property (disable iff (srst)
      cs_n [*5] |-> dout_oe_n)
      else $error("output driven while deselected");
   a_select_drives: assert property (disable iff (srst)
      $fell(cs_n) |-> ##[1:5] !dout_oe_n)
      else $error("output not driven after select");
   // a bit holds up to the rising edge; after the last rising edge
   // the line may go back to the ready level at once
   a_dout_steady: assert property (disable iff (srst)
      (!dout_oe_n && fall_ff >= 5'h03 && fall_ff <= 5'h07)
      |-> $stable(dout))
      else $error("output moved away from falling edge");
   a_ones_recover: assert property (disable iff (srst)
      $rose(ones_ff == 6'h20) |-> ##[1:8] dout)
      else $error("no reset after 32 ones");
   a_cmd_fixed_zero: assert property (disable iff (srst)
      (rise && bits_ff == 6'h01 && !first_ff) |-> !din)
      else $error("fixed command bit not zero");
   a_sclk_parks: assert property (disable iff (srst)
      cs_n |-> sclk)
      else $error("serial clock not parked high");
   a_sclk_half: assert property (disable iff (srst)
      $changed(sclk) |=> $stable(sclk) [*7])
      else $error("serial clock half period short");
   a_frame_length: assert property (disable iff (srst)
      $rose(cs_n) |-> (bits_ff == 6'h08 || bits_ff == 6'h10
                       || bits_ff == 6'h20))
      else $error("frame bit count wrong");

   c_recover: cover property ($rose(ones_ff == 6'h20));
   c_long_frame: cover property ($rose(cs_n) && bits_ff == 6'h20);
   c_ready_3w: cover property (!cs_n && sclk && $fell(dout_line));
endmodule // adc_port_properties
`default_nettype wire

// ### adc_port_tb_top.sv
// self-checking bench: host end drives converter end over one link,
// a second converter end is bit-banged by the bench.
// assumes 10 MHz core_clk shared by both ends.
`timescale 1ns/1ps
`default_nettype none
module adc_serial_command_port_tb_top;
   logic core_clk;
   logic srst;
   logic conv_done;
   logic [23:0] conv_data;
   logic update_soon;
   logic start;
   logic [7:0] cmd;
   logic [23:0] wdata;
   logic recover;
   logic three_wire;
   logic busy;
   logic done;
   logic [23:0] rdata;
   logic data_ready;
   logic [7:0] mode_q;
   logic [7:0] filter_q;
   logic [1:0] channel_q;
   logic continuous_read_bit_q;
   logic ready_q;
   logic [7:0] mode_b;
   logic seen;
   int n_mismatch;
   int checked;

   adc_port_if link ();
   adc_port_if link_b ();
   adc_port_dev adc_port_dev_inst (.core_clk(core_clk), .srst(srst),
      .link(link), .conv_done(conv_done), .conv_data(conv_data),
      .update_soon(update_soon), .mode_q(mode_q), .filter_q(filter_q),
      .channel_q(channel_q), .continuous_read_bit_q(continuous_read_bit_q), .ready_q(ready_q));
   adc_port_dev adc_port_dev_inst_b (.core_clk(core_clk), .srst(srst),
      .link(link_b), .conv_done(conv_done), .conv_data(conv_data),
      .update_soon(update_soon), .mode_q(mode_b), .filter_q(),
      .channel_q(), .continuous_read_bit_q(), .ready_q());
   adc_port_host adc_port_host_inst (.core_clk(core_clk), .srst(srst),
      .link(link), .start(start), .cmd(cmd), .wdata(wdata),
      .recover(recover), .three_wire(three_wire), .busy(busy),
      .done(done), .rdata(rdata), .data_ready(data_ready));
   adc_port_properties adc_port_properties_inst (.core_clk(core_clk),
      .srst(srst), .sclk(link.sclk), .cs_n(link.cs_n), .din(link.din),
      .dout(link.dout), .dout_oe_n(link.dout_oe_n),
      .dout_line(link.dout_line));

   always #50 core_clk = ~core_clk;

   // ***************************************************************
   // tasks
   // ***************************************************************
   task automatic conclude();
      $display("checked %0d n_mismatch %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic cmp(input logic [23:0] got, input logic [23:0] exp);
      checked = checked + 1;
      if (got !== exp) begin
         n_mismatch = n_mismatch + 1;
         $display("MISMATCH %0t value %h not %h", $time, got, exp);
      end
   endtask

   task automatic cmp_flag(input logic got, input logic exp);
      checked = checked + 1;
      if (got !== exp) begin
         n_mismatch = n_mismatch + 1;
         $display("MISMATCH %0t flag %b not %b", $time, got, exp);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask

   // one framed access, or a recovery frame when rec is set
   task automatic access(input logic rec, input logic [7:0] c,
                         input logic [23:0] w);
      int i;
      start = !rec;
      recover = rec;
      cmd = c;
      wdata = w;
      tick(1);
      cmp_flag(busy, 1'b1);
      start = 1'b0;
      recover = 1'b0;
      i = 0;
      while (done !== 1'b1 && i < 700) begin
         tick(1);
         i = i + 1;
      end
      if (i == 700) begin
         n_mismatch = n_mismatch + 1;
         $display("MISMATCH %0t no done", $time);
         conclude();
      end
      cmp_flag(busy, 1'b0);
   endtask

   task automatic conv(input logic [23:0] d);
      conv_done = 1'b1;
      conv_data = d;
      tick(1);
      conv_done = 1'b0;
   endtask

   // bench acts as host on the second link, 800 ns serial clock
   task automatic bang(input logic [7:0] v, input int n);
      for (int k = 7; k > 7 - n; k--) begin
         link_b.din = v[k];
         link_b.sclk = 1'b0;
         tick(4);
         link_b.sclk = 1'b1;
         tick(4);
      end
   endtask

   // ***************************************************************
   // sequence
   // ***************************************************************
   initial begin
      core_clk = 1'b0;
      srst = 1'b1;
      conv_done = 1'b0;
      conv_data = 24'h000000;
      update_soon = 1'b0;
      start = 1'b0;
      cmd = 8'h00;
      wdata = 24'h000000;
      recover = 1'b0;
      three_wire = 1'b0;
      link_b.sclk = 1'b1;
      link_b.cs_n = 1'b1;
      link_b.din = 1'b1;
      n_mismatch = 0;
      checked = 0;
      tick(20);
      srst = 1'b0;
      tick(3);
      cmp(24'({mode_q, filter_q}), 24'h000000);
      cmp(24'({continuous_read_bit_q, channel_q}), 24'h000000);
      cmp_flag(ready_q, 1'b0);
      cmp_flag(link.dout_line, 1'b1);
      access(1'b0, 8'h16, 24'h0000a5);
      cmp(24'(mode_q), 24'h0000a5);
      cmp(24'({continuous_read_bit_q, channel_q}), 24'h000006);
      access(1'b0, 8'h20, 24'h00003c);
      cmp(24'({mode_q, filter_q}), 24'h00a53c);
      access(1'b0, 8'h18, 24'h000000);
      cmp(24'(rdata[7:0]), 24'h0000a5);
      access(1'b0, 8'h28, 24'h000000);
      cmp(24'(rdata[7:0]), 24'h00003c);
      // write to a non-writable target has no data phase
      access(1'b0, 8'h00, 24'h000000);
      access(1'b0, 8'h28, 24'h000000);
      cmp(24'(rdata[7:0]), 24'h00003c);
      conv(24'h123456);
      cmp_flag(ready_q, 1'b1);
      access(1'b0, 8'h08, 24'h000000);
      cmp(24'(rdata[7:0]), 24'h000080);
      access(1'b0, 8'h38, 24'h000000);
      cmp(rdata, 24'h123456);
      three_wire = 1'b1;
      tick(6);
      conv(24'h00beef);
      seen = 1'b0;
      for (int i = 0; i < 30; i++) begin
         if (data_ready === 1'b1) seen = 1'b1;
         tick(1);
      end
      cmp_flag(seen, 1'b1);
      update_soon = 1'b1;
      tick(1);
      update_soon = 1'b0;
      tick(8);
      cmp_flag(link.dout_line, 1'b1);
      access(1'b0, 8'h38, 24'h000000);
      cmp(rdata, 24'h00beef);
      three_wire = 1'b0;
      tick(6);
      conv(24'h000001);
      access(1'b0, 8'h16, 24'h000077);
      access(1'b1, 8'h00, 24'h000000);
      cmp(24'(mode_q), 24'h000000);
      cmp_flag(ready_q, 1'b0);
      access(1'b0, 8'h20, 24'h000011);
      cmp(24'(filter_q), 24'h000011);
      link_b.cs_n = 1'b0;
      tick(4);
      bang(8'hff, 3);
      bang(8'h10, 8);
      bang(8'h5a, 8);
      link_b.cs_n = 1'b1;
      tick(8);
      cmp(24'(mode_b), 24'h00005a);
      conclude();
   end
endmodule // adc_serial_command_port_tb_top
`default_nettype wire
